/* File: hdl/hrs_irq.sv */
// Sticky event status with mask and one level interrupt
`timescale 1ns/1ps
module hrs_irq #(
   parameter int W = 5
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         pclk_en,
   // Events and software access
   input  wire logic [W-1:0] event_in,
   input  wire logic         clr_we,
   input  wire logic         mask_we,
   input  wire logic [W-1:0] wdata,
   // State
   output logic      [W-1:0] status,
   output logic      [W-1:0] mask,
   output logic              irq
);

   if (W < 1)
   begin : g_chk
      $error("hrs_irq: W must be at least 1");
   end

   // ----------------------------------------------------------------------
   // Status: a new event wins over a write-one clear
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status <= '0;
      else if (pclk_en)
         status <= (status & ~(clr_we ? wdata : '0)) | event_in;
   end

   // ----------------------------------------------------------------------
   // Mask
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask <= '0;
      else if (pclk_en && mask_we)
         mask <= wdata;
   end

   assign irq = |(status & mask);

endmodule

/* File: hdl/hrs_strap_capture.sv */
// Hub strap capture, port power polarity, over-current sense and APB registers
`timescale 1ns/1ps
`include "hrs_map.svh"
module hrs_strap_capture #(
   parameter int         ADDR_W           = 8,
   parameter int         PORTS            = `HRS_PORTS,
   parameter bit         HAS_POL_STRAP    = 1'b1,
   parameter bit         HAS_CFG_B2       = 1'b1,
   parameter bit         HAS_FIXED_STRAP  = 1'b1,
   parameter logic [2:0] FIXED_STRAP_CFG  = 3'h0
) (
   // Clock, enable and reset
   input  wire logic              pclk,
   input  wire logic              pclk_en,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Interrupt
   output logic                   irq,
   // Strap pins
   input  wire logic              power_polarity_strap,
   input  wire logic              fixed_port_strap_b1,
   input  wire logic              fixed_port_strap_b0,
   input  wire logic              config_method_b0,
   input  wire logic              config_method_b2,
   // Shared speed indicator pin
   input  wire logic              upstream_highspeed_led_in,
   output logic                   upstream_highspeed_led_out,
   output logic                   upstream_highspeed_led_oe,
   // Port power and over-current
   output logic      [PORTS-1:0]  port_power_out,
   input  wire logic [PORTS-1:0]  overcurrent_sense_n,
   // Decoded strap state
   output logic      [PORTS-1:0]  fixed_port_map,
   output logic      [2:0]        config_method
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (ADDR_W < 5 || ADDR_W > 32)
   begin : g_chk_addr
      $error("hrs_strap_capture: ADDR_W out of range");
   end
   if (PORTS != `HRS_PORTS)
   begin : g_chk_ports
      $error("hrs_strap_capture: PORTS must be four");
   end

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == ADDR_W'(off));
   endfunction

   function automatic logic [3:0] fixed_decode(input logic [1:0] code);
      unique case (code)
         2'h0:    fixed_decode = 4'h0;
         2'h1:    fixed_decode = 4'h1;
         2'h2:    fixed_decode = 4'h3;
         2'h3:    fixed_decode = 4'h7;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   hrs_pkg::hrs_phase_t           phase;
   hrs_pkg::hrs_straps_t          pin_straps;
   hrs_pkg::hrs_straps_t          sync_straps;
   hrs_pkg::hrs_straps_t          straps;
   logic [`HRS_CTRL_W-1:0]        ctrl;
   logic [PORTS-1:0]              oc_sync_n;
   logic [PORTS-1:0]              oc_now;
   logic [PORTS-1:0]              oc_prev;
   logic [PORTS-1:0]              oc_rise;
   logic [PORTS-1:0]              port_enable;
   logic                          cap_pulse;
   logic                          fixed_allowed;
   logic                          pol_active_high;
   logic                          pol_reset;
   logic                          hs_connected;
   logic                          ack_q;
   logic                          wr_fire;
   logic                          rd_err;
   logic [31:0]                   rd_word;
   logic [`HRS_IRQ_W-1:0]         irq_status;
   logic [`HRS_IRQ_W-1:0]         irq_mask;
   logic [`HRS_IRQ_W-1:0]         irq_events;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   always_comb
   begin
      pin_straps.pol   = power_polarity_strap;
      pin_straps.fixed = {fixed_port_strap_b1, fixed_port_strap_b0};
      pin_straps.cfg   = {HAS_CFG_B2 ? config_method_b2 : `HRS_CFG_ZERO,
                          upstream_highspeed_led_in,
                          config_method_b0};
   end

   hrs_sync #(
      .W       ($bits(hrs_pkg::hrs_straps_t))
   ) u_sync_straps (
      .pclk    (pclk),
      .pclk_en (pclk_en),
      .d       (pin_straps),
      .q       (sync_straps)
   );

   hrs_sync #(
      .W       (PORTS)
   ) u_sync_oc (
      .pclk    (pclk),
      .pclk_en (pclk_en),
      .d       (overcurrent_sense_n),
      .q       (oc_sync_n)
   );

   // ----------------------------------------------------------------------
   // Capture phase
   // ----------------------------------------------------------------------
   // Synchronisers run during reset, so the first edge after release
   // already sees the pins as they stood at release.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase <= hrs_pkg::PH_WAIT;
      else if (pclk_en)
      begin
         unique case (phase)
            hrs_pkg::PH_WAIT: phase <= hrs_pkg::PH_RUN;
            hrs_pkg::PH_RUN:  phase <= hrs_pkg::PH_RUN;
         endcase
      end
   end

   assign cap_pulse = pclk_en && (phase == hrs_pkg::PH_WAIT);

   // ----------------------------------------------------------------------
   // Strap latch
   // ----------------------------------------------------------------------
   // Written only in the capture cycle; shared pins may toggle freely after.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         straps <= '0;
      else if (cap_pulse)
         straps <= sync_straps;
   end

   // ----------------------------------------------------------------------
   // Strap decode
   // ----------------------------------------------------------------------
   assign fixed_allowed  = HAS_FIXED_STRAP && (straps.cfg == FIXED_STRAP_CFG);
   assign fixed_port_map = (phase == hrs_pkg::PH_RUN && fixed_allowed)
                           ? fixed_decode(straps.fixed) : `HRS_PORTS_RST;
   assign config_method  = straps.cfg;

   // ----------------------------------------------------------------------
   // Port power polarity
   // ----------------------------------------------------------------------
   // The reset path is purely combinational so a held reset never
   // depends on a clock edge to turn power off.
   assign pol_reset       = HAS_POL_STRAP ? power_polarity_strap : 1'b1;
   assign pol_active_high = !HAS_POL_STRAP ? 1'b1 :
                            (phase == hrs_pkg::PH_RUN) ? straps.pol
                                                       : sync_straps.pol;
   assign port_enable     = ctrl[PORTS-1:0];

   always_comb
   begin
      if (!presetn)
         port_power_out = {PORTS{~pol_reset}};
      else
         port_power_out = pol_active_high ? port_enable : ~port_enable;
   end

   // ----------------------------------------------------------------------
   // Upstream speed indicator
   // ----------------------------------------------------------------------
   // Pin stays an input until the method bit is caught.
   assign hs_connected = ctrl[`HRS_CTRL_HS_BIT];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         upstream_highspeed_led_out <= 1'b0;
         upstream_highspeed_led_oe  <= 1'b0;
      end
      else if (pclk_en && phase == hrs_pkg::PH_RUN)
      begin
         upstream_highspeed_led_out <= hs_connected ^ straps.cfg[1];
         upstream_highspeed_led_oe  <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Over-current sense
   // ----------------------------------------------------------------------
   assign oc_now  = ~oc_sync_n;
   assign oc_rise = oc_now & ~oc_prev;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         oc_prev <= `HRS_PORTS_RST;
      else if (pclk_en)
         oc_prev <= oc_now;
   end

   // ----------------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------------
   assign irq_events = {cap_pulse, pclk_en ? oc_rise : `HRS_PORTS_RST};

   hrs_irq #(
      .W        (`HRS_IRQ_W)
   ) u_irq (
      .pclk     (pclk),
      .presetn  (presetn),
      .pclk_en  (pclk_en),
      .event_in (irq_events),
      .clr_we   (wr_fire && hit(paddr, `HRS_OFF_IRQ_STAT)),
      .mask_we  (wr_fire && hit(paddr, `HRS_OFF_IRQ_MASK)),
      .wdata    (pwdata[`HRS_IRQ_W-1:0]),
      .status   (irq_status),
      .mask     (irq_mask),
      .irq      (irq)
   );

   // ----------------------------------------------------------------------
   // APB handshake
   // ----------------------------------------------------------------------
   // Read data is prepared in the setup cycle so prdata comes from a flop;
   // a transfer with pclk_en high in its setup and access cycles takes exactly one access cycle.
   assign pready  = psel && penable && ack_q && pclk_en;
   assign wr_fire = pready && pwrite;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ack_q <= 1'b0;
      else if (pclk_en)
      begin
         if (pready)
            ack_q <= 1'b0;
         else if (psel)
            ack_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------------
   always_comb
   begin
      rd_word = 32'h0;
      rd_err  = 1'b0;
      if (hit(paddr, `HRS_OFF_CTRL))
         rd_word = {{(32-`HRS_CTRL_W){1'b0}}, ctrl};
      else if (hit(paddr, `HRS_OFF_STRAP))
         rd_word = {{(32-`HRS_STRAP_W){1'b0}}, phase == hrs_pkg::PH_RUN, straps};
      else if (hit(paddr, `HRS_OFF_FIXED))
         rd_word = {{(32-PORTS){1'b0}}, fixed_port_map};
      else if (hit(paddr, `HRS_OFF_OC))
         rd_word = {{(32-PORTS){1'b0}}, oc_now};
      else if (hit(paddr, `HRS_OFF_IRQ_STAT))
         rd_word = {{(32-`HRS_IRQ_W){1'b0}}, irq_status};
      else if (hit(paddr, `HRS_OFF_IRQ_MASK))
         rd_word = {{(32-`HRS_IRQ_W){1'b0}}, irq_mask};
      else
         rd_err  = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end
      else if (pclk_en && psel && !ack_q)
      begin
         prdata  <= pwrite ? 32'h0 : rd_word;
         pslverr <= rd_err;
      end
   end

   // ----------------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------------
   // Unmapped writes are dropped and flagged by pslverr only.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= `HRS_CTRL_RST;
      else if (wr_fire && hit(paddr, `HRS_OFF_CTRL))
         ctrl <= pwdata[`HRS_CTRL_W-1:0];
   end

endmodule

/* File: hdl/hrs_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module hrs_sync #(
   parameter int W = 1
) (
   // Clock
   input  wire logic         pclk,
   input  wire logic         pclk_en,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] stage1;

   if (W < 1)
   begin : g_chk
      $error("hrs_sync: W must be at least 1");
   end

   // ----------------------------------------------------------------------
   // No reset: straps must be tracked while reset is held
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk)
   begin
      if (pclk_en)
      begin
         stage1 <= d;
         q      <= stage1;
      end
   end

endmodule

/* File: pkg/hrs_map.svh */
// Register offsets, field positions and reset values of the strap capture block
`ifndef HRS_MAP_SVH
`define HRS_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define HRS_OFF_CTRL      8'h00
`define HRS_OFF_STRAP     8'h04
`define HRS_OFF_FIXED     8'h08
`define HRS_OFF_OC        8'h0c
`define HRS_OFF_IRQ_STAT  8'h10
`define HRS_OFF_IRQ_MASK  8'h14

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define HRS_PORTS         4
`define HRS_CTRL_W        5
`define HRS_CTRL_HS_BIT   4
`define HRS_IRQ_W         5
`define HRS_IRQ_CAP_BIT   4
`define HRS_STRAP_W       7
`define HRS_STRAP_DONE    6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define HRS_CTRL_RST      5'h00
`define HRS_IRQ_RST       5'h00
`define HRS_PORTS_RST     4'h0
`define HRS_CFG_ZERO      1'b0

`endif

/* File: pkg/hrs_pkg.sv */
// Types shared by the strap capture block
package hrs_pkg;

   // ----------------------------------------------------------------------
   // Strap values caught at reset release
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [2:0] cfg;
      logic [1:0] fixed;
      logic       pol;
   } hrs_straps_t;

   // ----------------------------------------------------------------------
   // Capture phase
   // ----------------------------------------------------------------------
   typedef enum logic {
      PH_WAIT,
      PH_RUN
   } hrs_phase_t;

endpackage

/* File: tb/hrs_port_switch.sv */
// Model of the external port power switches and current monitors
`timescale 1ns/1ps
module hrs_port_switch (
   // Control from the hub
   input  wire logic       active_high,
   input  wire logic [3:0] port_power_out,
   // Fault injection
   input  wire logic [3:0] fault,
   // Open-drain monitor lines and switch state
   output wire       [3:0] overcurrent_sense_n,
   output logic      [3:0] powered
);
   assign powered = active_high ? port_power_out : ~port_power_out;
   // Monitor trips only on a powered port; a released line rests at the pull-up
   for (genvar i = 0; i < 4; i++)
   begin : g_mon
      assign overcurrent_sense_n[i] = (fault[i] && powered[i]) ? 1'b0 : 1'bz;
   end
endmodule

/* File: tb/hrs_strap_capture_bench.sv */
// Self-checking bench for the strap capture block
`timescale 1ns/1ps
module hrs_strap_capture_bench;
   typedef struct packed {logic pol, b1, b0, m0, m1, m2, hs; logic [3:0] map;} hrs_row_t;
   hrs_row_t rows [6] = '{11'b1000001_0000, 11'b0010000_0001, 11'b1100000_0011,
                          11'b0110001_0111, 11'b1111101_0000, 11'b0110110_0000};
   logic        pclk, pclk_en, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        e, pol_pin, fb1_pin, fb0_pin, cm0_pin, cm2_pin, led_ext, led_out, led_oe;
   logic [3:0]  power, power_b, map, fault, powered;
   logic [2:0]  cfg, cfg_b;
   wire         led_in;
   tri1  [3:0]  oc_n;
   int          bad_count, samples_checked;
   assign led_in = led_oe ? led_out : led_ext;
   hrs_strap_capture u_hrs_strap_capture (.pclk(pclk), .pclk_en(pclk_en), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .power_polarity_strap(pol_pin), .fixed_port_strap_b1(fb1_pin),
      .fixed_port_strap_b0(fb0_pin), .config_method_b0(cm0_pin), .config_method_b2(cm2_pin),
      .upstream_highspeed_led_in(led_in), .upstream_highspeed_led_out(led_out),
      .upstream_highspeed_led_oe(led_oe), .port_power_out(power), .overcurrent_sense_n(oc_n),
      .fixed_port_map(map), .config_method(cfg));
   // Package variant without polarity and method bit 2 pins
   hrs_strap_capture #(.HAS_POL_STRAP(1'b0), .HAS_CFG_B2(1'b0)) u_hrs_strap_capture_alt (.pclk(pclk),
      .pclk_en(pclk_en), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .irq(), .power_polarity_strap(pol_pin),
      .fixed_port_strap_b1(fb1_pin), .fixed_port_strap_b0(fb0_pin), .config_method_b0(cm0_pin),
      .config_method_b2(cm2_pin), .upstream_highspeed_led_in(led_in), .upstream_highspeed_led_out(),
      .upstream_highspeed_led_oe(), .port_power_out(power_b), .overcurrent_sense_n(oc_n),
      .fixed_port_map(), .config_method(cfg_b));
   hrs_port_switch u_hrs_port_switch (.active_high(pol_pin), .port_power_out(power), .fault(fault),
      .overcurrent_sense_n(oc_n), .powered(powered));
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task final_report;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task check(input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x)
      begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   // Idle edge first, so psel is never assigned twice in one step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No local limit: the watchdog ends a hung wait
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      check(r, x);
   endtask
   task start(input hrs_row_t t);
      presetn <= 1'b0;
      {pol_pin, fb1_pin, fb0_pin, cm0_pin, led_ext, cm2_pin} <= {t.pol, t.b1, t.b0, t.m0, t.m1, t.m2};
      repeat (10) @(posedge pclk);
      check({28'h0, power}, {28'h0, {4{~t.pol}}});
      check({28'h0, power_b}, 32'h0);
      pol_pin <= ~t.pol;
      @(posedge pclk);
      check({28'h0, power}, {28'h0, {4{t.pol}}});
      pol_pin <= t.pol;
      repeat (10) @(posedge pclk);
      check({25'h0, cfg, map}, 32'h0);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   initial
   begin
      {pclk_en, presetn, psel, penable, pwrite, paddr, pwdata, fault} = {3'b100, 46'h0};
      {pol_pin, fb1_pin, fb0_pin, cm0_pin, cm2_pin, led_ext} = 6'h20;
      {bad_count, samples_checked} = {32'h0, 32'h0};
      @(posedge pclk);
      for (int i = 0; i < 6; i++)
      begin
         start(rows[i]);
         rd(8'h04, {25'h1, rows[i].m2, rows[i].m1, rows[i].m0, rows[i].b1, rows[i].b0, rows[i].pol});
         rd(8'h08, {28'h0, rows[i].map});
         check({29'h0, cfg_b}, {30'h0, rows[i].m1, rows[i].m0});
         apb(1'b1, 8'h00, {27'h0, rows[i].hs, 4'h5});
         repeat (2) @(posedge pclk);
         check({28'h0, power}, rows[i].pol ? 32'h5 : 32'ha);
         check({28'h0, power_b}, 32'h5);
         check({30'h0, led_oe, led_out}, {30'h0, 1'b1, rows[i].hs ^ rows[i].m1});
         // Shared pins take up run-time roles
         {pol_pin, fb1_pin, fb0_pin, cm0_pin, cm2_pin} <= ~{pol_pin, fb1_pin, fb0_pin, cm0_pin, cm2_pin};
         repeat (4) @(posedge pclk);
         check({25'h0, cfg, map}, {25'h0, rows[i].m2, rows[i].m1, rows[i].m0, rows[i].map});
         check({28'h0, power}, rows[i].pol ? 32'h5 : 32'ha);
         $display("row test %0d done", i);
      end
      start(rows[0]);
      rd(8'h0c, 32'h0);
      apb(1'b1, 8'h00, 32'hf);
      fault <= 4'h2;
      repeat (5) @(posedge pclk);
      rd(8'h0c, 32'h2);
      rd(8'h10, 32'h12);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, 8'h14, 32'h2);
      @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, 8'h14, 32'h0);
      apb(1'b1, 8'h10, 32'h2);
      rd(8'h10, 32'h10);
      fault <= 4'h0;
      $display("interrupt test done");
      // Enable low must freeze the pin path, so no event can arrive
      apb(1'b1, 8'h14, 32'h4);
      pclk_en <= 1'b0;
      fault <= 4'h4;
      repeat (6) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      pclk_en <= 1'b1;
      repeat (4) @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      fault <= 4'h0;
      $display("enable test done");
      rd(8'h20, 32'h0);
      check({31'h0, e}, 32'h1);
      apb(1'b1, 8'h04, 32'hff);
      rd(8'h04, 32'h41);
      $display("refusal test done");
      final_report();
   end
   initial
   begin
      repeat (5000) @(posedge pclk);
      bad_count++;
      final_report();
   end
endmodule

/* File: tb/hrs_strap_chk.sv */
// Concurrent checks on the strap capture block ports
`timescale 1ns/1ps
module hrs_strap_chk #(
   parameter int ADDR_W        = 8,
   parameter int PORTS         = 4,
   parameter bit HAS_POL_STRAP = 1'b1
) (
   // Clock and reset
   input wire logic              pclk,
   input wire logic              pclk_en,
   input wire logic              presetn,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              irq,
   // Pins and decoded state
   input wire logic              power_polarity_strap,
   input wire logic              upstream_highspeed_led_out,
   input wire logic              upstream_highspeed_led_oe,
   input wire logic [PORTS-1:0]  port_power_out,
   input wire logic [PORTS-1:0]  fixed_port_map,
   input wire logic [2:0]        config_method
);
   logic pol_seen;
   logic wr_ctrl;
   logic wr_mask;
   assign wr_ctrl = psel && penable && pready && pwrite && paddr == 8'h00;
   assign wr_mask = psel && penable && pready && pwrite && paddr == 8'h14;
   // Pin held steady in reset, so the sampled copy is what the capture took
   always_ff @(posedge pclk)
   begin
      if (!presetn)
      begin
         pol_seen <= HAS_POL_STRAP ? power_polarity_strap : 1'b1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rst_power;
      // Sampled reset, so the edge that asserts reset is not judged
      disable iff (1'b0)
         !presetn |-> port_power_out == (HAS_POL_STRAP ? {PORTS{~power_polarity_strap}} : '0);
   endproperty
   a_rst_power: assert property (p_rst_power) else $error("port power active in reset");
   property p_power_run;
      wr_ctrl |=> port_power_out == (pol_seen ? $past(pwdata[PORTS-1:0]) : ~$past(pwdata[PORTS-1:0]));
   endproperty
   a_power_run: assert property (p_power_run) else $error("port power polarity wrong");
   property p_led;
      wr_ctrl |=> ##1 upstream_highspeed_led_out == ($past(pwdata[4], 2) ^ config_method[1]);
   endproperty
   a_led: assert property (p_led) else $error("speed indicator level wrong");
   property p_oe;
      $past(presetn, 2) |-> upstream_highspeed_led_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("speed indicator not driven");
   property p_cfg_hold;
      $past(presetn, 2) |-> $stable(config_method);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("latched method moved");
   property p_fixed_gate;
      $past(presetn, 2) && config_method != 3'h0 |-> fixed_port_map == '0;
   endproperty
   a_fixed_gate: assert property (p_fixed_gate) else $error("fixed map not gated");
   property p_fixed_code;
      ((fixed_port_map + 1'b1) & fixed_port_map) == '0 && !fixed_port_map[PORTS-1];
   endproperty
   a_fixed_code: assert property (p_fixed_code) else $error("fixed map not a valid code");
   property p_pulse;
      pready |-> psel && penable ##1 !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pready not a single pulse");
   property p_nowait;
      psel && !penable && pclk_en ##1 penable && pclk_en |-> pready;
   endproperty
   a_nowait: assert property (p_nowait) else $error("access phase waited");
   property p_err;
      pready && paddr > 8'h14 |-> pslverr;
   endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_mask;
      wr_mask && pwdata[4:0] == 5'h00 |=> !irq;
   endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt raised");
endmodule

bind hrs_strap_capture hrs_strap_chk #(.ADDR_W(ADDR_W), .PORTS(PORTS), .HAS_POL_STRAP(HAS_POL_STRAP))
   u_hrs_strap_chk (.pclk(pclk), .pclk_en(pclk_en), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq(irq),
   .power_polarity_strap(power_polarity_strap), .upstream_highspeed_led_out(upstream_highspeed_led_out),
   .upstream_highspeed_led_oe(upstream_highspeed_led_oe), .port_power_out(port_power_out),
   .fixed_port_map(fixed_port_map), .config_method(config_method));
